// ==== common/tsc_regs.vh ====
// register numbers, field positions, reset values and timing for the bank
`ifndef TSC_REGS_VH
`define TSC_REGS_VH

// resource identifier form: (number << 8) | kind
`define TSC_RES_SHIFT        8
`define TSC_RES_KIND         8'h0b

// register numbers
`define TSC_REG_VECTOR_BASE  8'h01
`define TSC_REG_FEATURE_CTRL 8'h02
`define TSC_REG_BOOT_STATUS  8'h03
`define TSC_REG_SECURITY     8'h05
`define TSC_REG_OSC_CTRL     8'h06
`define TSC_REG_OSC_CORE_CEL 8'h07
`define TSC_REG_OSC_CORE_WIR 8'h08
`define TSC_REG_OSC_PER_CEL  8'h09
`define TSC_REG_OSC_PER_WIR  8'h0a

// writable masks
`define TSC_VBASE_MASK       32'hfff80000
`define TSC_CTRL_MASK        32'h00001f11
`define TSC_SEC_MASK         32'h800043a1
`define TSC_OSC_CTRL_MASK    32'h00000003

// field positions
`define TSC_CTRL_SIZE_HI     12
`define TSC_CTRL_SIZE_LO     11
`define TSC_CTRL_RAM_DOWN    10
`define TSC_CTRL_AUTO_SLEEP  9
`define TSC_CTRL_CSI_PORTS   8
`define TSC_CTRL_CLK_DIV     4
`define TSC_CTRL_EXT_MEM     0
`define TSC_SEC_WRITE_LOCK   31
`define TSC_SEC_NO_GLOBAL_DBG 14
`define TSC_SEC_OTP_RD_LOCK  9
`define TSC_SEC_OTP_PRG_OFF  8
`define TSC_SEC_FUSE_BOOT    5
`define TSC_SEC_NO_TILE_JTAG 0
`define TSC_OSC_CORE_RUN     1
`define TSC_OSC_PERIPH_RUN   0

// reset values
`define TSC_CTRL_RESET       32'h00001800
`define TSC_VBASE_RESET      32'h00000000

// vector split
`define TSC_VEC_HALF         16

// settle time before reading a count, in core clocks
`define TSC_OSC_SETTLE_CYC   10

`endif

// ==== hw/tsc_status_bank.v ====
// tile processor status register bank with ring oscillator counters
//
// Behaviour
// [R01] handler address: upper 16 bits from vector base, lower from event
// [R02] vector base keeps bits 31:19; bits 18:0 read zero
// [R03] external memory size code at bits 12:11, resets to 3
// [R04] bit 10 powers down tile RAMs, resets 0
// [R05] bit 9 enables memory auto-sleep, resets 0
// [R06] bit 8 enables camera-serial peripheral ports, resets 0
// [R07] bit 4 enables PLL clock divider for low power, resets 0
// [R08] bit 0 enables external memory; other reserved bits read zero
// [R09] boot status read-only; processor number at bits 23:16
// [R10] boot flags: override, skip poll, RAM, JTAG, PLL mode pins
// [R11] security register loaded from one-time-programmable security word
// [R12] security bit 31 removes write permission on that register
// [R13] security bit 9 blocks fuse reads; bit 8 blocks programming
// [R14] security bit 14 disables global debug; bit 0 tile debug TAP
// [R15] security bit 5 forces boot image from fuse memory
// [R16] four ring oscillators each clock a counter, started by control
// [R17] control bit 1 runs core oscillators, bit 0 peripheral ones
// [R18] software reads a count only after 10 stopped core cycles
// [R19] oscillators and counters run asynchronous to the tile clock
// [R20] counts read as 16 bits, upper bits zero
// [R21] counters keep their counts across system reset
// [R22] counts at register numbers 0x07, 0x08, 0x09, 0x0a
// [R23] access by status read/write word; id is number<<8 or 0x0b
// [R24] writes to reserved or read-only bits ignored, except security bit 7, which is stored and read back; reserved read zero
// [R25] while locked, security writes change nothing
`timescale 1ns/1ns
`include "tsc_regs.vh"

module tsc_status_bank
(
  // clock and reset
  input  wire        ref_clk_in,
  input  wire        rst_n_in,
  // processor status access
  input  wire        ps_read_in,
  input  wire        ps_write_in,
  input  wire [15:0] ps_res_id_in,
  input  wire [31:0] ps_wdata_in,
  output reg  [31:0] ps_rdata_out,
  output reg         ps_rvalid_out,
  output reg         ps_id_error_out,
  // event vector to handler address
  input  wire        event_take_in,
  input  wire [15:0] event_vector_in,
  output reg  [31:0] handler_addr_out,
  // fuse security word load
  input  wire        fuse_load_in,
  input  wire [31:0] fuse_security_word_in,
  // boot status pins and straps
  input  wire [7:0]  processor_number_in,
  input  wire        boot_skip_otp_poll_in,
  input  wire        boot_from_ram_in,
  input  wire        boot_from_jtag_in,
  input  wire [1:0]  pll_mode_pins_in,
  // ring oscillator clocks
  input  wire        osc_core_cell_in,
  input  wire        osc_core_wire_in,
  input  wire        osc_periph_cell_in,
  input  wire        osc_periph_wire_in,
  // tile feature controls
  output reg  [1:0]  ext_memory_size_code_out,
  output reg         ram_power_down_out,
  output reg         memory_auto_sleep_on_out,
  output reg         csi_ports_on_out,
  output reg         pll_divider_on_out,
  output reg         ext_memory_if_on_out,
  // security controls
  output reg         otp_read_block_out,
  output reg         otp_program_block_out,
  output reg         global_debug_off_out,
  output reg         tile_jtag_off_out,
  output reg         fuse_boot_override_out,
  // oscillator run enables
  output reg         core_osc_run_out,
  output reg         periph_osc_run_out
);

  reg  [31:0] vector_base_r;
  reg  [31:0] feature_ctrl_r;
  reg  [31:0] security_r;
  reg  [1:0]  osc_ctrl_r;
  reg  [31:0] boot_status_r;
  reg  [31:0] rdata_nxt;

  // the straps and pins pass two flops before use
  reg  [12:0] boot_meta_r;
  reg  [12:0] boot_sync_r;

  wire [7:0]  reg_num;
  wire        id_ok;
  wire        wr;
  wire        rd;
  wire [15:0] cnt_cc;
  wire [15:0] cnt_cw;
  wire [15:0] cnt_pc;
  wire [15:0] cnt_pw;
  reg  [15:0] cnt_sync0_r;
  reg  [15:0] cnt_sync1_r;
  reg  [15:0] cnt_sync2_r;
  reg  [15:0] cnt_sync3_r;

  // [R23] decode resource identifier
  assign reg_num = ps_res_id_in[15:`TSC_RES_SHIFT];
  assign id_ok   = (ps_res_id_in[7:0] == `TSC_RES_KIND);
  assign wr      = ps_write_in & id_ok;
  assign rd      = ps_read_in & id_ok;

  // [R16] one counter per oscillator
  tsc_osc_counter u_cnt_cc
  (
    .osc_clk_in (osc_core_cell_in),
    .run_in     (osc_ctrl_r[`TSC_OSC_CORE_RUN]),
    .count_out  (cnt_cc)
  );
  tsc_osc_counter u_cnt_cw
  (
    .osc_clk_in (osc_core_wire_in),
    .run_in     (osc_ctrl_r[`TSC_OSC_CORE_RUN]),
    .count_out  (cnt_cw)
  );
  tsc_osc_counter u_cnt_pc
  (
    .osc_clk_in (osc_periph_cell_in),
    .run_in     (osc_ctrl_r[`TSC_OSC_PERIPH_RUN]),
    .count_out  (cnt_pc)
  );
  tsc_osc_counter u_cnt_pw
  (
    .osc_clk_in (osc_periph_wire_in),
    .run_in     (osc_ctrl_r[`TSC_OSC_PERIPH_RUN]),
    .count_out  (cnt_pw)
  );

  // [R18] counts sampled twice; stable once oscillator stopped
  // the count word crosses domains unguarded; it is only coherent
  // once its oscillator has stopped and both stages have settled
  always @(posedge ref_clk_in)
  begin
    cnt_sync0_r <= cnt_cc;
    cnt_sync1_r <= cnt_cw;
    cnt_sync2_r <= cnt_pc;
    cnt_sync3_r <= cnt_pw;
  end

  // second stage of each count synchroniser
  reg [15:0] cnt_stab0_r;
  reg [15:0] cnt_stab1_r;
  reg [15:0] cnt_stab2_r;
  reg [15:0] cnt_stab3_r;
  always @(posedge ref_clk_in)
  begin
    cnt_stab0_r <= cnt_sync0_r;
    cnt_stab1_r <= cnt_sync1_r;
    cnt_stab2_r <= cnt_sync2_r;
    cnt_stab3_r <= cnt_sync3_r;
  end

  // boot status straps through two flops
  always @(posedge ref_clk_in)
  begin
    boot_meta_r <= {processor_number_in, boot_skip_otp_poll_in,
                    boot_from_ram_in, boot_from_jtag_in,
                    pll_mode_pins_in};
    boot_sync_r <= boot_meta_r;
  end

  // [R10] boot flags and [R09] processor number
  always @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      boot_status_r <= 32'h00000000;
    else
      boot_status_r <= {8'h00,
                        boot_sync_r[12:5],
                        7'h00,
                        security_r[`TSC_SEC_FUSE_BOOT],
                        3'h0,
                        boot_sync_r[4:0]};
  end

  // register writes
  always @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      vector_base_r  <= `TSC_VBASE_RESET;
      feature_ctrl_r <= `TSC_CTRL_RESET;
      security_r     <= 32'h00000000;
      osc_ctrl_r     <= 2'b00;
    end
    else
    begin
      // [R02] only bits 31:19 stored
      if (wr && reg_num == `TSC_REG_VECTOR_BASE)
        vector_base_r <= ps_wdata_in & `TSC_VBASE_MASK;
      // [R24] masked writes to feature control
      if (wr && reg_num == `TSC_REG_FEATURE_CTRL)
        feature_ctrl_r <= ps_wdata_in & `TSC_CTRL_MASK;
      // [R11] fuse copy loads the security word
      // a fuse copy in the same cycle as a software write wins
      if (fuse_load_in)
        security_r <= fuse_security_word_in & `TSC_SEC_MASK;
      // [R12] lock bit blocks writes
      // [R25] locked register unchanged
      else if (wr && reg_num == `TSC_REG_SECURITY &&
               !security_r[`TSC_SEC_WRITE_LOCK])
        security_r <= ps_wdata_in & `TSC_SEC_MASK;
      // [R17] oscillator run bits
      if (wr && reg_num == `TSC_REG_OSC_CTRL)
        osc_ctrl_r <= ps_wdata_in[1:0];
    end
  end

  // read mux
  always @*
  begin
    rdata_nxt = 32'h00000000;
    case (reg_num)
      `TSC_REG_VECTOR_BASE:  rdata_nxt = vector_base_r;
      `TSC_REG_FEATURE_CTRL: rdata_nxt = feature_ctrl_r;
      `TSC_REG_BOOT_STATUS:  rdata_nxt = boot_status_r;
      `TSC_REG_SECURITY:     rdata_nxt = security_r;
      `TSC_REG_OSC_CTRL:     rdata_nxt = {30'h0, osc_ctrl_r};
      // [R22] count register numbers
      // [R20] 16-bit counts, upper bits zero
      `TSC_REG_OSC_CORE_CEL: rdata_nxt = {16'h0000, cnt_stab0_r};
      `TSC_REG_OSC_CORE_WIR: rdata_nxt = {16'h0000, cnt_stab1_r};
      `TSC_REG_OSC_PER_CEL:  rdata_nxt = {16'h0000, cnt_stab2_r};
      `TSC_REG_OSC_PER_WIR:  rdata_nxt = {16'h0000, cnt_stab3_r};
      // [R24] unknown numbers read zero
      default:               rdata_nxt = 32'h00000000;
    endcase
  end

  // read answer one cycle after request
  always @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      ps_rdata_out    <= 32'h00000000;
      ps_rvalid_out   <= 1'b0;
      ps_id_error_out <= 1'b0;
    end
    else
    begin
      ps_rvalid_out   <= rd;
      ps_rdata_out    <= rd ? rdata_nxt : 32'h00000000;
      // a wrong resource kind only raises the error pulse
      ps_id_error_out <= (ps_read_in | ps_write_in) & ~id_ok;
    end
  end

  // [R01] handler address formed on event
  always @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      handler_addr_out <= 32'h00000000;
    else if (event_take_in)
      handler_addr_out <= {vector_base_r[31:`TSC_VEC_HALF],
                           event_vector_in};
  end

  // control outputs from registers
  always @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      ext_memory_size_code_out <= 2'h3;
      ram_power_down_out       <= 1'b0;
      memory_auto_sleep_on_out <= 1'b0;
      csi_ports_on_out         <= 1'b0;
      pll_divider_on_out       <= 1'b0;
      ext_memory_if_on_out     <= 1'b0;
      otp_read_block_out       <= 1'b0;
      otp_program_block_out    <= 1'b0;
      global_debug_off_out     <= 1'b0;
      tile_jtag_off_out        <= 1'b0;
      fuse_boot_override_out   <= 1'b0;
      core_osc_run_out         <= 1'b0;
      periph_osc_run_out       <= 1'b0;
    end
    else
    begin
      // outputs follow their register bits one clock later
      // [R03] size code
      ext_memory_size_code_out <=
        feature_ctrl_r[`TSC_CTRL_SIZE_HI:`TSC_CTRL_SIZE_LO];
      // [R04] RAM power down
      ram_power_down_out       <= feature_ctrl_r[`TSC_CTRL_RAM_DOWN];
      // [R05] auto sleep
      memory_auto_sleep_on_out <= feature_ctrl_r[`TSC_CTRL_AUTO_SLEEP];
      // [R06] csi ports
      csi_ports_on_out         <= feature_ctrl_r[`TSC_CTRL_CSI_PORTS];
      // [R07] clock divider
      pll_divider_on_out       <= feature_ctrl_r[`TSC_CTRL_CLK_DIV];
      // [R08] external memory
      ext_memory_if_on_out     <= feature_ctrl_r[`TSC_CTRL_EXT_MEM];
      // [R13] fuse access blocks
      otp_read_block_out       <= security_r[`TSC_SEC_OTP_RD_LOCK];
      otp_program_block_out    <= security_r[`TSC_SEC_OTP_PRG_OFF];
      // [R14] debug disables
      global_debug_off_out     <= security_r[`TSC_SEC_NO_GLOBAL_DBG];
      tile_jtag_off_out        <= security_r[`TSC_SEC_NO_TILE_JTAG];
      // [R15] boot override
      fuse_boot_override_out   <= security_r[`TSC_SEC_FUSE_BOOT];
      // [R17] run enables
      core_osc_run_out         <= osc_ctrl_r[`TSC_OSC_CORE_RUN];
      periph_osc_run_out       <= osc_ctrl_r[`TSC_OSC_PERIPH_RUN];
    end
  end

endmodule

// counter clocked by a ring oscillator
module tsc_osc_counter
(
  // oscillator side
  input  wire        osc_clk_in,
  input  wire        run_in,
  // count
  output wire [15:0] count_out
);

  reg [1:0]  run_sync_r;
  // power-up value only; no reset ever clears the count
  reg [15:0] count_r = 16'h0000;

  // [R19] runs on oscillator clock only
  // [R21] no reset: count survives system reset
  always @(posedge osc_clk_in)
  begin
    // run enable enters the oscillator domain through two flops
    run_sync_r <= {run_sync_r[0], run_in};
    if (run_sync_r[1])
      count_r <= count_r + 16'h0001;
  end

  assign count_out = count_r;

endmodule

// ==== sim/tsc_status_bank_checker.sv ====
// assertion checker for the tile status register bank
`timescale 1ns/1ns
module tsc_chk
(
  // clock and reset
  input wire        ref_clk_in,
  input wire        rst_n_in,
  // status access
  input wire        ps_read_in,
  input wire        ps_write_in,
  input wire [15:0] ps_res_id_in,
  input wire [31:0] ps_wdata_in,
  input wire [31:0] ps_rdata_out,
  input wire        ps_rvalid_out,
  input wire        ps_id_error_out,
  // event and controls
  input wire        event_take_in,
  input wire [15:0] event_vector_in,
  input wire [31:0] handler_addr_out,
  input wire        ext_memory_if_on_out,
  input wire        core_osc_run_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire       ok_w = ps_res_id_in[7:0] == 8'h0b;
  wire       rd_w = ps_read_in && ok_w;
  wire [7:0] rn_w = ps_res_id_in[15:8];

  property p_read; rd_w |=> ps_rvalid_out; endproperty
  a_read: assert property (p_read) else $error("read unanswered");
  property p_bad;
    (ps_read_in || ps_write_in) && !ok_w |=> ps_id_error_out && !ps_rvalid_out;
  endproperty
  a_bad: assert property (p_bad) else $error("bad id accepted");
  property p_unk; rd_w && rn_w == 8'h04 |=> ps_rdata_out == 32'h0; endproperty
  a_unk: assert property (p_unk) else $error("unknown not zero");
  property p_vb; rd_w && rn_w == 8'h01 |=> ps_rdata_out[18:0] == 19'h0;
  endproperty
  a_vb: assert property (p_vb) else $error("base low bits set");
  property p_ctl;
    rd_w && rn_w == 8'h02 |=> (ps_rdata_out & 32'hffffe0ee) == 32'h0;
  endproperty
  a_ctl: assert property (p_ctl) else $error("ctrl reserved set");
  property p_cnt;
    rd_w && rn_w inside {[8'h07:8'h0a]} |=> ps_rdata_out[31:16] == 16'h0;
  endproperty
  a_cnt: assert property (p_cnt) else $error("count upper set");
  property p_hnd;
    event_take_in |=> handler_addr_out[15:0] == $past(event_vector_in);
  endproperty
  a_hnd: assert property (p_hnd) else $error("handler low wrong");
  property p_ext;
    ps_write_in && ps_res_id_in == 16'h020b
      |=> ##1 ext_memory_if_on_out == $past(ps_wdata_in[0], 2);
  endproperty
  a_ext: assert property (p_ext) else $error("ext mem enable wrong");
  property p_osc;
    ps_write_in && ps_res_id_in == 16'h060b
      |=> ##1 core_osc_run_out == $past(ps_wdata_in[1], 2);
  endproperty
  a_osc: assert property (p_osc) else $error("core osc run wrong");
  c_read: cover property (ps_rvalid_out);
  c_err: cover property (ps_id_error_out);
  c_evt: cover property (event_take_in);
endmodule

bind tsc_status_bank tsc_chk u_chk (.*);

// ==== sim/tb_tsc_status_bank.sv ====
// self-checking bench for the tile status register bank
`timescale 1ns/1ns
module tb_tsc_status_bank;
  localparam [31:0] F = 32'hffffffff;
  localparam [31:0] H = 32'hffff0000;
  reg ref_clk_in, rst_n_in, ps_read_in, ps_write_in, event_take_in;
  reg fuse_load_in, boot_skip_otp_poll_in, boot_from_ram_in;
  reg boot_from_jtag_in;
  reg [15:0] ps_res_id_in, event_vector_in;
  reg [31:0] ps_wdata_in, fuse_security_word_in, s, r, v, c;
  reg [7:0]  processor_number_in;
  reg [1:0]  pll_mode_pins_in;
  reg [3:0]  osc_r = 4'h0;
  reg [67:0] q[$];
  reg [67:0] x;
  reg [31:0] seen [0:15];
  int n_errors = 0;
  int num_checks = 0;
  wire [31:0] ps_rdata_out, handler_addr_out;
  wire [1:0]  ext_memory_size_code_out;
  wire ps_rvalid_out, ps_id_error_out, ram_power_down_out;
  wire memory_auto_sleep_on_out, csi_ports_on_out, pll_divider_on_out;
  wire ext_memory_if_on_out, otp_read_block_out, otp_program_block_out;
  wire global_debug_off_out, tile_jtag_off_out, fuse_boot_override_out;
  wire core_osc_run_out, periph_osc_run_out;
  wire osc_core_cell_in = osc_r[0];
  wire osc_core_wire_in = osc_r[1];
  wire osc_periph_cell_in = osc_r[2];
  wire osc_periph_wire_in = osc_r[3];
  wire [6:0] ctl_w = {ext_memory_size_code_out, ram_power_down_out,
    memory_auto_sleep_on_out, csi_ports_on_out, pll_divider_on_out,
    ext_memory_if_on_out};
  wire [4:0] sec_w = {global_debug_off_out, otp_read_block_out,
    otp_program_block_out, fuse_boot_override_out, tile_jtag_off_out};
  wire [1:0] osc_w = {core_osc_run_out, periph_osc_run_out};

  tsc_status_bank u_dut (.*);

  function automatic [31:0] xs();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function automatic [31:0] bexp(input fb);
    return {8'h0, processor_number_in, 7'h0, fb, 3'h0,
      boot_skip_otp_poll_in, boot_from_ram_in, boot_from_jtag_in,
      pll_mode_pins_in};
  endfunction
  task automatic chk(input string n, input [31:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  // one request per cycle; reads of kind 0x0b note the expected word
  task automatic acc(input wr, input [15:0] id, input [31:0] d, m, e);
    @(negedge ref_clk_in);
    ps_write_in = wr;
    ps_read_in = !wr;
    ps_res_id_in = id;
    ps_wdata_in = d;
    if (!wr && id[7:0] == 8'h0b)
      q.push_back({id[11:8], m, e});
  endtask
  task automatic idle(input int n);
    @(negedge ref_clk_in);
    {ps_read_in, ps_write_in, fuse_load_in, event_take_in} = 4'h0;
    repeat (n) @(negedge ref_clk_in);
  endtask
  task automatic rst;
    rst_n_in = 0;
    repeat (10) @(negedge ref_clk_in);
    rst_n_in = 1;
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    ref_clk_in = 0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  always #3 osc_r = osc_r + 4'h1;
  // read results compared against the oldest note
  initial forever
  begin
    @(negedge ref_clk_in);
    if (ps_rvalid_out === 1'b1)
    begin
      if (q.size() == 0)
        chk("rvalid", 0, 1);
      else
      begin
        x = q.pop_front();
        seen[x[67:64]] = ps_rdata_out;
        chk("rdata", x[31:0], ps_rdata_out & x[63:32]);
      end
    end
  end
  initial
  begin
    #200000;
    n_errors++;
    stop_test;
  end

  initial
  begin
    s = 32'h41;
    {ps_read_in, ps_write_in, fuse_load_in, event_take_in} = 4'h0;
    ps_res_id_in = 0;
    ps_wdata_in = 0;
    event_vector_in = 0;
    fuse_security_word_in = 0;
    r = xs();
    {processor_number_in, boot_skip_otp_poll_in, boot_from_ram_in,
      boot_from_jtag_in, pll_mode_pins_in} = r[12:0];
    rst;
    acc(0, 16'h020b, 0, F, 32'h1800);
    acc(0, 16'h010b, 0, F, 0);
    acc(0, 16'h060b, 0, F, 0);
    acc(0, 16'h030b, 0, F, bexp(0));
    idle(2);
    chk("ctl", 7'h60, ctl_w);
    $display("test reset values done");
    repeat (8)
    begin
      r = xs();
      acc(1, 16'h010b, r, 0, 0);
      acc(1, 16'h020b, r, 0, 0);
      acc(1, 16'h060b, r, 0, 0);
      acc(1, 16'h030b, r, 0, 0);
      acc(0, 16'h010b, 0, F, r & 32'hfff80000);
      acc(0, 16'h020b, 0, F, r & 32'h1f11);
      acc(0, 16'h060b, 0, F, r & 32'h3);
      acc(0, 16'h030b, 0, F, bexp(0));
      idle(2);
      chk("ctl", {r[12:8], r[4], r[0]}, ctl_w);
      chk("osc", r[1:0], osc_w);
    end
    v = xs();
    @(negedge ref_clk_in);
    event_vector_in = v[15:0];
    event_take_in = 1;
    idle(1);
    chk("handler", {r[31:19], 3'h0, v[15:0]}, handler_addr_out);
    acc(0, 16'h010c, 0, 0, 0);
    acc(0, 16'h040b, 0, F, 0);
    chk("id_error", 1, ps_id_error_out);
    idle(0);
    $display("test random access done");
    v = xs() & 32'h7fffffff | 32'h20;
    @(negedge ref_clk_in);
    fuse_security_word_in = v;
    fuse_load_in = 1;
    idle(2);
    acc(0, 16'h050b, 0, F, v & 32'h800043a1);
    acc(0, 16'h030b, 0, F, bexp(1));
    idle(2);
    chk("sec", {v[14], v[9], v[8], 1'b1, v[0]}, sec_w);
    r = xs() & 32'h7fffffff;
    acc(1, 16'h050b, r, 0, 0);
    acc(0, 16'h050b, 0, F, r & 32'h43a1);
    acc(1, 16'h050b, F, 0, 0);
    acc(1, 16'h050b, 0, 0, 0);
    acc(0, 16'h050b, 0, F, 32'h800043a1);
    idle(2);
    chk("sec", 5'h1f, sec_w);
    $display("test security done");
    acc(1, 16'h060b, 3, 0, 0);
    idle(60);
    acc(1, 16'h060b, 0, 0, 0);
    idle(12);
    for (int i = 7; i <= 10; i++)
      acc(0, {8'(i), 8'h0b}, 0, H, 0);
    idle(2);
    c = seen[7];
    v = seen[10];
    acc(1, 16'h060b, 1, 0, 0);
    idle(60);
    acc(1, 16'h060b, 0, 0, 0);
    idle(12);
    acc(0, 16'h070b, 0, F, c);
    acc(0, 16'h0a0b, 0, H, 0);
    idle(2);
    chk("count moved", 1, seen[10] !== v);
    rst;
    acc(0, 16'h0a0b, 0, F, seen[10]);
    idle(2);
    chk("ctl", 7'h60, ctl_w);
    $display("test oscillators done");
    stop_test;
  end
endmodule
